// File: inc/nfc_pkg.sv
// Constants and types of the NAND flash host controller
package nfc_pkg;
	localparam int CLK_MHZ              = 25;
	localparam int ADDR_TO_DATA_NS      = 70;
	localparam int PROTECT_TO_STROBE_NS = 100;
	localparam int READY_TO_READ_NS     = 20;
	localparam int STROBE_LOW_NS        = 40;
	localparam int STROBE_HIGH_NS       = 40;
	localparam int ADDRESS_TO_DATA_WAIT  = (ADDR_TO_DATA_NS * CLK_MHZ + 999) / 1000;
	localparam int PROTECT_TO_STROBE_WAIT = (PROTECT_TO_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int READY_TO_READ_WAIT    = (READY_TO_READ_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_LOW_CYC       = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_HIGH_CYC      = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int PARTIAL_PROGRAM_LIMIT = 4;
	localparam logic [7:0] STATUS_PROTECTED = 8'h60;
	localparam logic [7:0] CMD_READ        = 8'h00;
	localparam logic [7:0] CMD_READ_GO     = 8'h30;
	localparam logic [7:0] CMD_CACHE_RD    = 8'h31;
	localparam logic [7:0] CMD_CACHE_END   = 8'h3F;
	localparam logic [7:0] CMD_RAND_OUT    = 8'h05;
	localparam logic [7:0] CMD_RAND_OUT_GO = 8'hE0;
	localparam logic [7:0] CMD_RAND_IN     = 8'h85;
	localparam logic [7:0] CMD_PROG        = 8'h80;
	localparam logic [7:0] CMD_PROG_GO     = 8'h10;
	localparam logic [7:0] CMD_CACHE_PROG  = 8'h15;
	localparam logic [7:0] CMD_ERASE       = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO    = 8'hD0;
	localparam logic [7:0] CMD_ID          = 8'h90;
	localparam logic [7:0] CMD_PARAM       = 8'hEC;
	localparam logic [7:0] CMD_UID         = 8'hED;
	localparam logic [7:0] CMD_SET_FEAT    = 8'hEF;
	localparam logic [7:0] CMD_GET_FEAT    = 8'hEE;
	localparam logic [7:0] CMD_RESET       = 8'hFF;
	localparam logic [7:0] CMD_STATUS      = 8'h70;
	localparam logic [7:0] CMD_PROT_STAT   = 8'h7A;
	// Host request kinds
	typedef enum logic [2:0] {
		NFC_OP_CMD   = 3'b000,
		NFC_OP_ADDR  = 3'b001,
		NFC_OP_WDATA = 3'b010,
		NFC_OP_RDATA = 3'b011,
		NFC_OP_WAIT  = 3'b100
	} nfc_op_type;
	typedef enum logic [2:0] {
		NFC_IDLE  = 3'b000,
		NFC_SETUP = 3'b001,
		NFC_LOW   = 3'b010,
		NFC_HIGH  = 3'b011,
		NFC_BUSY  = 3'b100,
		NFC_DONE  = 3'b101
	} nfc_state_type;
endpackage

// File: core/nfc_timer.sv
// Down counter for pin timing gaps
`timescale 1ns/1ns
`default_nettype none
module nfc_timer
	import nfc_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	input  wire logic       load_in,
	input  wire logic [3:0] count_in,
	output var  logic       done_out
);
	typedef struct packed {
		logic [3:0] cnt;
	} nfc_timer_type;
	nfc_timer_type state_reg;
	nfc_timer_type state_next;
	always_comb begin
		state_next = state_reg;
		if (load_in) begin
			state_next.cnt = count_in;
		end else if (state_reg.cnt != 4'h0) begin
			state_next.cnt = state_reg.cnt - 4'h1;
		end
	end
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	// Load left out: the caller loads on done, which would close a loop
	assign done_out = (state_reg.cnt == 4'h0);
endmodule
`default_nettype wire

// File: core/nfc_host.sv
// Host controller driving NAND flash pins
`timescale 1ns/1ns
`default_nettype none
module nfc_host
	import nfc_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	input  wire logic       req_valid_in,
	input  wire logic [2:0] req_op_in,
	input  wire logic [7:0] req_data_in,
	input  wire logic       req_wp_in,
	output logic            req_ready_out,
	output logic            rsp_valid_out,
	output logic [7:0]      rsp_data_out,
	output logic            rsp_protected_out,
	output logic            prog_limit_out,
	output logic            chip_sel_n_out,
	output logic            cmd_latch_out,
	output logic            addr_latch_out,
	output logic            write_strobe_n_out,
	output logic            read_strobe_n_out,
	output logic            write_protect_n_out,
	output logic [7:0]      io_out,
	output logic            io_oe_out,
	input  wire logic [7:0] io_in,
	input  wire logic       ready_busy_n_in
);

	typedef struct packed {
		nfc_state_type st;
		logic [2:0]    op;
		logic [7:0]    data;
		logic          ready;
		logic          rsp_valid;
		logic [7:0]    rsp_data;
		logic          rsp_prot;
		logic          last_addr;
		logic          status_rd;
		logic [2:0]    prog_cnt;
		logic          limit;
		logic          ce_n;
		logic          cle;
		logic          ale;
		logic          we_n;
		logic          re_n;
		logic          wp_n;
		logic [7:0]    io;
		logic          oe;
	} nfc_host_type;

	nfc_host_type s_reg;
	nfc_host_type s_next;

	// One gap timer, reloaded by every phase except high and done
	logic       t_load;
	logic [3:0] t_count;
	logic       t_done;

	nfc_timer u_timer (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.load_in  (t_load),
		.count_in (t_count),
		.done_out (t_done)
	);

	always_comb begin
		s_next = s_reg;
		t_load = 1'b0;
		t_count = 4'h0;
		s_next.rsp_valid = 1'b0;
		case (s_reg.st)
			NFC_IDLE: begin
				s_next.ready = 1'b1;
				// Ready drops on accept so a held valid is taken once
				if (req_valid_in && s_reg.ready) begin
					s_next.ready = 1'b0;
					s_next.op = req_op_in;
					s_next.data = req_data_in;
					s_next.ce_n = 1'b0;
					s_next.wp_n = req_wp_in;
					s_next.st = NFC_SETUP;
					t_load = 1'b1;
					t_count = 4'(PROTECT_TO_STROBE_WAIT);

					if (req_op_in == NFC_OP_WDATA && s_reg.last_addr) begin
						t_count = 4'(ADDRESS_TO_DATA_WAIT);
					end

					// Wait skips the strobes and only polls busy
					if (req_op_in == NFC_OP_WAIT) begin
						s_next.st = NFC_BUSY;
						t_count = 4'(STROBE_HIGH_CYC);
					end
				end
			end

			NFC_SETUP: begin
				if (t_done) begin
					s_next.cle = (s_reg.op == NFC_OP_CMD);
					s_next.ale = (s_reg.op == NFC_OP_ADDR);
					s_next.io = s_reg.data;
					s_next.oe = (s_reg.op != NFC_OP_RDATA);
					if (s_reg.op == NFC_OP_RDATA) begin
						s_next.re_n = 1'b0;
					end else begin
						s_next.we_n = 1'b0;
					end

					// Low phase length sets both pulse widths
					t_load = 1'b1;
					t_count = 4'(STROBE_LOW_CYC);
					s_next.st = NFC_LOW;
				end
			end

			NFC_LOW: begin
				if (t_done) begin
					// Byte taken late in the low phase, past access time
					if (s_reg.op == NFC_OP_RDATA) begin
						s_next.rsp_data = io_in;
						s_next.rsp_valid = 1'b1;
						s_next.rsp_prot = s_reg.status_rd && (io_in == STATUS_PROTECTED);
					end

					s_next.we_n = 1'b1;
					s_next.re_n = 1'b1;
					t_load = 1'b1;
					t_count = 4'(STROBE_HIGH_CYC);
					s_next.st = NFC_HIGH;
				end
			end

			NFC_HIGH: begin
				if (t_done) begin
					s_next.cle = 1'b0;
					s_next.ale = 1'b0;
					s_next.oe = 1'b0;
					s_next.last_addr = (s_reg.op == NFC_OP_ADDR);
					if (s_reg.op == NFC_OP_CMD) begin
						s_next.status_rd = (s_reg.data == CMD_STATUS);
						if (s_reg.data == CMD_ERASE_GO) begin
							s_next.prog_cnt = 3'h0;
						end
						if (s_reg.data == CMD_PROG_GO || s_reg.data == CMD_CACHE_PROG) begin
							// Saturates until the next erase confirm
							if (s_reg.prog_cnt != 3'(PARTIAL_PROGRAM_LIMIT)) begin
								s_next.prog_cnt = s_reg.prog_cnt + 3'h1;
							end
						end
					end

					s_next.st = NFC_DONE;
				end
			end

			NFC_BUSY: begin
				// Short hold first: the device may drop ready late
				// Await ready level
				if (t_done && ready_busy_n_in) begin
					t_load = 1'b1;
					t_count = 4'(READY_TO_READ_WAIT);
					s_next.st = NFC_HIGH;
					s_next.op = NFC_OP_WAIT;
				end
			end

			NFC_DONE: begin
				if (t_done) begin
					s_next.rsp_valid = (s_reg.op != NFC_OP_RDATA);
					s_next.ready = 1'b1;
					s_next.st = NFC_IDLE;
				end
			end

			default: begin
				s_next.st = NFC_IDLE;
			end
		endcase

		s_next.limit = (s_next.prog_cnt == 3'(PARTIAL_PROGRAM_LIMIT));
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			// Select and strobes idle high, pins quiet
			s_reg <= '0;
			s_reg.ce_n <= 1'b1;
			s_reg.we_n <= 1'b1;
			s_reg.re_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign req_ready_out       = s_reg.ready;
	assign rsp_valid_out       = s_reg.rsp_valid;
	assign rsp_data_out        = s_reg.rsp_data;
	assign rsp_protected_out   = s_reg.rsp_prot;
	assign prog_limit_out      = s_reg.limit;
	assign chip_sel_n_out      = s_reg.ce_n;
	assign cmd_latch_out       = s_reg.cle;
	assign addr_latch_out      = s_reg.ale;
	assign write_strobe_n_out  = s_reg.we_n;
	assign read_strobe_n_out   = s_reg.re_n;
	assign write_protect_n_out = s_reg.wp_n;
	assign io_out              = s_reg.io;
	assign io_oe_out           = s_reg.oe;

endmodule
`default_nettype wire

// File: verification/nfc_host_sva.sv
// Pin protocol checks for the flash host
`timescale 1ns/1ns
`default_nettype none
module nfc_host_sva (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic rsp_valid_out,
	input wire logic chip_sel_n_out,
	input wire logic cmd_latch_out,
	input wire logic addr_latch_out,
	input wire logic write_strobe_n_out,
	input wire logic read_strobe_n_out,
	input wire logic write_protect_n_out,
	input wire logic io_oe_out,
	input wire logic ready_busy_n_in
);
	wire ws = write_strobe_n_out;
	wire rs = read_strobe_n_out;
	wire wp = write_protect_n_out;
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	a_cmd_cycle: assert property (!ws && cmd_latch_out |-> !addr_latch_out && !chip_sel_n_out && rs)
		else $error("bad command cycle");
	a_addr_cycle: assert property (!ws && addr_latch_out |-> !cmd_latch_out && !chip_sel_n_out && rs)
		else $error("bad address cycle");
	a_read_cycle: assert property (!rs |-> ws && !io_oe_out && !cmd_latch_out && !addr_latch_out)
		else $error("bad read cycle");
	a_write_drive: assert property ($fell(ws) |-> io_oe_out && !chip_sel_n_out ##2 ws)
		else $error("bad write strobe");
	a_wp_setup: assert property ($rose(ws) |-> wp == $past(wp) && wp == $past(wp, 2) && wp == $past(wp, 3))
		else $error("protect pin moved too late");
	a_addr_gap: assert property ($rose(ws) && addr_latch_out |-> ws [*3])
		else $error("data too soon after address");
	a_ready_gap: assert property ($rose(ready_busy_n_in) |-> rs)
		else $error("read strobe too soon after ready");
	a_rsp_pulse: assert property (rsp_valid_out |=> !rsp_valid_out)
		else $error("response longer than a cycle");
	c_cmd: cover property (!ws && cmd_latch_out);
	c_read: cover property (!rs);
	c_ready: cover property ($rose(ready_busy_n_in));
endmodule
bind nfc_host nfc_host_sva u_sva (.clock_in, .rst_in, .rsp_valid_out, .chip_sel_n_out, .cmd_latch_out,
	.addr_latch_out, .write_strobe_n_out, .read_strobe_n_out, .write_protect_n_out, .io_oe_out, .ready_busy_n_in);
`default_nettype wire

// File: verification/nfc_flash_model.sv
// Behavioural flash device facing the host
`timescale 1ns/1ns
`default_nettype none
module nfc_flash_model (
	input wire logic       ce_n_in,
	input wire logic       cle_in,
	input wire logic       we_n_in,
	input wire logic       re_n_in,
	input wire logic       wp_n_in,
	input wire logic [7:0] io_in,
	output logic [7:0]     io_out,
	output logic           rb_n_out
);
	logic busy = 0, prot = 0, stat = 0;
	logic [7:0] rd = 8'hA0;
	int t;
	initial io_out = 8'h00;
	assign rb_n_out = !busy;
	always @(posedge we_n_in) if (!ce_n_in && cle_in && re_n_in && (!busy || io_in == 8'hFF || io_in == 8'h70)) begin
		stat = io_in == 8'h70;
		t = 0;
		case (io_in)
			8'h30: begin t = 25000; rd = 8'hA0; end
			8'h31, 8'h3F: t = 25000;
			8'hEF, 8'hEE: t = 1000;
			8'hFF: begin t = 5000; prot = 0; end
			// all blocks protected, gated by pin
			8'h10, 8'h15, 8'hD0: if (wp_n_in) begin t = 3000; prot = 1; end
			default: t = 0;
		endcase
		// Later release may be cut short by reset
		if (t > 0) begin busy <= 1; busy <= #(t) 0; end
	end
	always @(negedge re_n_in) if (!ce_n_in) begin
		io_out = stat ? (prot ? 8'h60 : 8'hE0) : rd;
		rd = stat ? rd : rd + 8'h01;
	end
	// Released bus shows garbage, not last byte
	always @(posedge re_n_in) io_out <= #15 ~io_out;
endmodule
`default_nettype wire

// File: verification/nfc_host_bench.sv
// Self-checking bench for the flash host
`timescale 1ns/1ns
`default_nettype none
module nfc_host_bench
	import nfc_pkg::*;
;
	logic clock_in = 0, rst_in = 1, req_valid_in = 0, req_wp_in = 0;
	logic [2:0] req_op_in = 3'h0;
	logic [7:0] req_data_in = 8'h00, rsp_data_out, io_out, dev_q;
	logic req_ready_out, rsp_valid_out, rsp_prot, limit, ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_n;
	int err_count = 0, samples_checked = 0, cyc = 0;
	wire [7:0] bus = oe ? io_out : dev_q;
	`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; $display("unexpected %0t: %h", $time, a); end end
	nfc_host dut (.clock_in(clock_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_op_in(req_op_in),
		.req_data_in(req_data_in), .req_wp_in(req_wp_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
		.rsp_data_out(rsp_data_out), .rsp_protected_out(rsp_prot), .prog_limit_out(limit), .chip_sel_n_out(ce_n),
		.cmd_latch_out(cle), .addr_latch_out(ale), .write_strobe_n_out(we_n), .read_strobe_n_out(re_n),
		.write_protect_n_out(wp_n), .io_out(io_out), .io_oe_out(oe), .io_in(bus), .ready_busy_n_in(rb_n));
	nfc_flash_model dev (.ce_n_in(ce_n), .cle_in(cle), .we_n_in(we_n), .re_n_in(re_n), .wp_n_in(wp_n),
		.io_in(bus), .io_out(dev_q), .rb_n_out(rb_n));
	always #20 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 30000) begin err_count++; finish_test(); end
	end
	task automatic req(input int op, input logic [7:0] d);
		req_op_in <= 3'(op);
		req_data_in <= d;
		req_valid_in <= 1;
		do @(posedge clock_in); while (req_ready_out !== 1);
		req_valid_in <= 0;
		do @(posedge clock_in); while (rsp_valid_out !== 1);
	endtask
	task automatic prog(input logic [7:0] conf);
		req(0, 8'h80);
		repeat (5) req(1, 8'h00);
		req(2, 8'h5A);
		req(0, conf);
		req(4, 8'h00);
	endtask
	task automatic status(input logic [7:0] exp, input logic p);
		req(0, 8'h70);
		req(3, 8'h00);
		`CHK(rsp_data_out, exp)
		`CHK(rsp_prot, p)
	endtask
	task automatic t_wp_inhibit();
		req_wp_in <= 0;
		req(0, 8'hFF);
		req(4, 8'h00);
		prog(8'h10);
		status(8'hE0, 1'b0);
	endtask
	task automatic t_protect();
		req_wp_in <= 1;
		prog(8'h15);
		status(8'h60, 1'b1);
	endtask
	task automatic t_read_page();
		int c;
		req(0, 8'h00);
		repeat (5) req(1, 8'h00);
		req(0, 8'h30);
		c = cyc;
		req(4, 8'h00);
		`CHK(1'(cyc - c > 600), 1'b1)
		for (int i = 0; i < 2; i++) begin
			req(3, 8'h00);
			`CHK(rsp_data_out, 8'hA0 + 8'(i))
		end
	endtask
	task automatic t_prog_limit();
		req_wp_in <= 1;
		req(0, 8'h60);
		repeat (3) req(1, 8'h00);
		req(0, 8'hD0);
		req(4, 8'h00);
		for (int i = 0; i < 4; i++) begin
			prog(8'h10);
			`CHK(limit, 1'(i == 3))
		end
	endtask
	task finish_test();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clock_in);
		rst_in <= 0;
		t_wp_inhibit();
		t_protect();
		t_read_page();
		t_prog_limit();
		finish_test();
	end
endmodule
`default_nettype wire
